// >>> rtl/misc_cfg_pkg.sv
// constants for the configuration header and error-reporting control bank
package misc_cfg_pkg;
    // register byte offsets
    localparam logic [11:0] OFF_IDENT = 12'h000;
    localparam logic [11:0] OFF_CLASS = 12'h008;
    localparam logic [11:0] OFF_HEADER = 12'h00C;
    localparam logic [11:0] OFF_ENABLES = 12'h040;
    localparam logic [11:0] OFF_ACTION = 12'h044;
    localparam logic [11:0] OFF_STAT_LO = 12'h048;
    localparam logic [11:0] OFF_STAT_HI = 12'h04C;
    localparam logic [11:0] OFF_ADDR_LO = 12'h050;
    localparam logic [11:0] OFF_ADDR_HI = 12'h054;
    localparam logic [11:0] OFF_MEMCTL_XBAR = 12'h078;
    localparam logic [11:0] OFF_FREE_LIST = 12'h07C;
    localparam logic [11:0] OFF_PWR_LOW = 12'h080;
    localparam logic [11:0] OFF_PWR_HIGH = 12'h084;
    localparam logic [11:0] OFF_APER_CTRL = 12'h090;
    localparam logic [11:0] OFF_APER_BASE = 12'h094;
    localparam logic [11:0] OFF_REMAP_BASE = 12'h098;
    localparam logic [11:0] OFF_REMAP_CACHE = 12'h09C;
    localparam logic [11:0] OFF_PWR_MISC = 12'h0A0;
    localparam logic [11:0] OFF_SPARE_RANK = 12'h0B0;
    localparam logic [11:0] OFF_CLK_TIM_LOW = 12'h0D4;
    localparam logic [11:0] OFF_CLK_TIM_HIGH = 12'h0D8;
    localparam logic [11:0] OFF_RDPTR_TUNE = 12'h0DC;
    localparam logic [11:0] OFF_THERM_TRIP = 12'h0E4;
    localparam logic [11:0] OFF_NB_CAPS = 12'h0E8;
    localparam logic [11:0] OFF_FAMILY_MODEL = 12'h0FC;
    localparam logic [11:0] EXT_CFG_BASE = 12'h100;
    // identity values: arbitrary, not those of any real part
    localparam logic [15:0] DEVICE_CODE = 16'h5A01;
    localparam logic [15:0] MAKER_CODE = 16'hC0DE;
    localparam logic [7:0] REVISION_BYTE = 8'h00;
    localparam logic [31:0] FAMILY_MODEL_VALUE = 32'h0000_0000;
    // header field values
    localparam logic [7:0] BASE_CLASS_BYTE = 8'h06;
    localparam logic [7:0] SUBCLASS_BYTE = 8'h00;
    localparam logic [7:0] PROG_IF_BYTE = 8'h00;
    localparam logic [7:0] HEADER_LAYOUT_BYTE = 8'h80;
    localparam logic [7:0] SELF_TEST_BYTE = 8'h00;
    localparam logic [7:0] LATENCY_TIMER_BYTE = 8'h00;
    localparam logic [7:0] CACHE_LINE_SIZE_BYTE = 8'h00;
    // reporting-enable bit positions
    localparam logic [4:0] BIT_CORR_ECC = 5'h00;
    localparam logic [4:0] BIT_UNCORR_ECC = 5'h01;
    localparam logic [4:0] BIT_LINK0_CRC = 5'h02;
    localparam logic [4:0] BIT_LINK2_SYNC = 5'h07;
    localparam logic [4:0] BIT_MASTER_ABORT = 5'h08;
    localparam logic [4:0] BIT_TARGET_ABORT = 5'h09;
    localparam logic [4:0] BIT_TABLE_WALK = 5'h0A;
    localparam logic [4:0] BIT_ATOMIC_RMW = 5'h0B;
    localparam logic [4:0] BIT_WATCHDOG = 5'h0C;
    localparam logic [4:0] BIT_MEM_PARITY = 5'h12;
    localparam logic [31:0] ENABLES_MASK = 32'h0004_1FFF;
    localparam logic [31:0] ENABLES_RESET = 32'h0000_0000;
    localparam logic [31:0] ACTION_MASK = 32'h7BF3_FFFF;
    localparam logic [31:0] ACTION_RESET = 32'h0000_0000;
    // upper status field positions
    localparam int ST_VALID = 31;
    localparam int ST_OVERFLOW = 30;
    localparam int ST_UNCORR = 29;
    localparam int ST_REPORT_EN = 28;
    // side-path register selects
    localparam logic [2:0] SIDE_ENABLES = 3'h0;
    localparam logic [2:0] SIDE_STAT_LO = 3'h1;
    localparam logic [2:0] SIDE_STAT_HI = 3'h2;
    localparam logic [2:0] SIDE_ADDR_LO = 3'h3;
    localparam logic [2:0] SIDE_ADDR_HI = 3'h4;
    // plain storage registers
    localparam int MISC_COUNT = 13;
    localparam logic [3:0] MISC_NONE = 4'hF;
    localparam logic [31:0] MEMCTL_XBAR_RESET = 32'h0800_3800;
    localparam logic [31:0] FREE_LIST_RESET = 32'h0000_221B;
    localparam logic [31:0] MISC_DEFAULT_RESET = 32'h0000_0000;
    localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;
endpackage

// >>> rtl/misc_config_header.sv
// configuration header and error-reporting control bank of the misc-control function
`timescale 1ns/1ps
// Summary of operation
// [R1] unimplemented standard locations read zero
// [R2] software avoids extended unimplemented locations
// [R3] identity word: device code over maker
// [R4] class word: host bridge, zero sub/if
// [R5] header layout byte reads 80h
// [R6] self-test, latency, line-size bytes read zero
// [R7] action register reachable by config only
// [R8] enables gate reporting, never other actions
// [R9] report needs local and global enable
// [R10] error logs survive warm reset
// [R11] logs capture status and address
// [R12] ecc, crc, sync enables at bits 0-7
// [R13] abort, walk, rmw, watchdog, parity enables
// [R14] enables reset zero, reserved read zero
// [R15] correctable enable only sets status enable
// [R16] crc or sync event floods links
// [R17] aborts answer error with all ones
// [R18] reads one access, read-only writes ignored
module misc_config_header import misc_cfg_pkg::*; (
    // clock and resets
    input wire logic clk,
    input wire logic rst_n,
    input wire logic warmReset,
    // global machine-check enable
    input wire logic globalMcEn,
    // configuration access
    input wire logic cfgReq,
    input wire logic cfgWrite,
    input wire logic [11:0] cfgAddr,
    input wire logic [31:0] cfgWdata,
    output logic [31:0] cfgRdata,
    output logic cfgAck,
    // model-specific register path
    input wire logic msrReq,
    input wire logic msrWrite,
    input wire logic [2:0] msrSel,
    input wire logic [31:0] msrWdata,
    output logic [31:0] msrRdata,
    output logic msrAck,
    // error events
    input wire logic errValid,
    input wire logic [4:0] errType,
    input wire logic errUncorrected,
    input wire logic [63:0] errAddr,
    // error actions
    output logic mcReport,
    output logic syncFlood,
    output logic errRespValid,
    output logic [31:0] errRespData
);
    logic [31:0] enablesReg;
    logic [31:0] actionReg;
    logic [31:0] statLoReg;
    logic [31:0] statHiReg;
    logic [31:0] addrLoReg;
    logic [31:0] addrHiReg;
    logic [31:0] miscReg [MISC_COUNT];
    logic [31:0] cfgReadValue;
    logic [31:0] sideReadValue;

    function automatic logic [3:0] misc_index(input logic [11:0] a);
        case (a)
            OFF_MEMCTL_XBAR: misc_index = 4'h0;
            OFF_FREE_LIST: misc_index = 4'h1;
            OFF_PWR_LOW: misc_index = 4'h2;
            OFF_PWR_HIGH: misc_index = 4'h3;
            OFF_APER_CTRL: misc_index = 4'h4;
            OFF_APER_BASE: misc_index = 4'h5;
            OFF_REMAP_BASE: misc_index = 4'h6;
            OFF_REMAP_CACHE: misc_index = 4'h7;
            OFF_PWR_MISC: misc_index = 4'h8;
            OFF_SPARE_RANK: misc_index = 4'h9;
            OFF_CLK_TIM_LOW: misc_index = 4'hA;
            OFF_CLK_TIM_HIGH: misc_index = 4'hB;
            OFF_RDPTR_TUNE: misc_index = 4'hC;
            default: misc_index = MISC_NONE;
        endcase
    endfunction

    // access decode; config wins a same-cycle collision, the side request is dropped
    wire [11:0] wordAddr = {cfgAddr[11:2], 2'b00};
    wire sideTake = msrReq & ~cfgReq;
    wire cfgWr = cfgReq & cfgWrite;
    wire sideWr = sideTake & msrWrite;
    wire [31:0] wrData = cfgReq ? cfgWdata : msrWdata;
    wire [3:0] miscIdx = misc_index(wordAddr);
    wire wrEnables = (cfgWr & (wordAddr == OFF_ENABLES)) | (sideWr & (msrSel == SIDE_ENABLES));
    wire wrAction = cfgWr & (wordAddr == OFF_ACTION); // R7
    wire wrStatLo = (cfgWr & (wordAddr == OFF_STAT_LO)) | (sideWr & (msrSel == SIDE_STAT_LO));
    wire wrStatHi = (cfgWr & (wordAddr == OFF_STAT_HI)) | (sideWr & (msrSel == SIDE_STAT_HI));
    wire wrAddrLo = (cfgWr & (wordAddr == OFF_ADDR_LO)) | (sideWr & (msrSel == SIDE_ADDR_LO));
    wire wrAddrHi = (cfgWr & (wordAddr == OFF_ADDR_HI)) | (sideWr & (msrSel == SIDE_ADDR_HI));
    wire wrMisc = cfgWr & (miscIdx != MISC_NONE);

    // event classification
    wire [31:0] typeBit = 32'h0000_0001 << errType;
    wire evEnabled = |(enablesReg & typeBit);
    wire isCorrectable = errType == BIT_CORR_ECC;
    wire reportEvent = errValid & evEnabled & globalMcEn & ~isCorrectable; // R9 R15
    wire floodEvent = errValid & (errType >= BIT_LINK0_CRC) & (errType <= BIT_LINK2_SYNC); // R16
    wire abortEvent = errValid & ((errType == BIT_MASTER_ABORT) | (errType == BIT_TARGET_ABORT));
    wire captureEvent = errValid & ~statHiReg[ST_VALID];
    wire overflowEvent = errValid & statHiReg[ST_VALID];

    always_comb begin
        cfgReadValue = 32'h0000_0000; // R1
        case (wordAddr)
            OFF_IDENT: cfgReadValue = {DEVICE_CODE, MAKER_CODE}; // R3
            OFF_CLASS: cfgReadValue = {BASE_CLASS_BYTE, SUBCLASS_BYTE, PROG_IF_BYTE,
                                       REVISION_BYTE}; // R4
            OFF_HEADER: cfgReadValue = {SELF_TEST_BYTE, HEADER_LAYOUT_BYTE, LATENCY_TIMER_BYTE,
                                        CACHE_LINE_SIZE_BYTE}; // R5 R6
            OFF_ENABLES: cfgReadValue = enablesReg;
            OFF_ACTION: cfgReadValue = actionReg;
            OFF_STAT_LO: cfgReadValue = statLoReg;
            OFF_STAT_HI: cfgReadValue = statHiReg;
            OFF_ADDR_LO: cfgReadValue = addrLoReg;
            OFF_ADDR_HI: cfgReadValue = addrHiReg;
            OFF_FAMILY_MODEL: cfgReadValue = FAMILY_MODEL_VALUE;
            default: begin
                // thermal trip and capability words fall here and read zero
                if (miscIdx != MISC_NONE) begin
                    cfgReadValue = miscReg[miscIdx];
                end
            end
        endcase
        // extended space is undefined; zero is the safe answer
        if (cfgAddr >= EXT_CFG_BASE) begin
            cfgReadValue = 32'h0000_0000;
        end
    end

    always_comb begin
        case (msrSel)
            SIDE_ENABLES: sideReadValue = enablesReg;
            SIDE_STAT_LO: sideReadValue = statLoReg;
            SIDE_STAT_HI: sideReadValue = statHiReg;
            SIDE_ADDR_LO: sideReadValue = addrLoReg;
            SIDE_ADDR_HI: sideReadValue = addrHiReg;
            default: sideReadValue = 32'h0000_0000;
        endcase
    end

    // read answers, one cycle after the request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfgRdata <= 32'h0000_0000;
            cfgAck <= 1'b0;
            msrRdata <= 32'h0000_0000;
            msrAck <= 1'b0;
        end else begin
            cfgAck <= cfgReq; // R18
            cfgRdata <= (cfgReq & ~cfgWrite) ? cfgReadValue : 32'h0000_0000;
            msrAck <= sideTake;
            msrRdata <= (sideTake & ~msrWrite) ? sideReadValue : 32'h0000_0000;
        end
    end

    // control words: cleared by cold and warm reset alike
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enablesReg <= ENABLES_RESET;
            actionReg <= ACTION_RESET;
        end else if (warmReset) begin
            enablesReg <= ENABLES_RESET;
            actionReg <= ACTION_RESET;
        end else begin
            if (wrEnables) begin
                enablesReg <= wrData & ENABLES_MASK; // R12 R13 R14
            end
            if (wrAction) begin
                actionReg <= wrData & ACTION_MASK;
            end
        end
    end

    // error logs: only a cold reset clears them, so a warm restart can still see them
    always_ff @(posedge clk or negedge rst_n) begin // R10
        if (!rst_n) begin
            statLoReg <= 32'h0000_0000;
            statHiReg <= 32'h0000_0000;
            addrLoReg <= 32'h0000_0000;
            addrHiReg <= 32'h0000_0000;
        end else if (captureEvent) begin
            // capture wins over a same-cycle software write
            statLoReg <= {27'h0, errType}; // R11
            statHiReg <= {1'b1, 1'b0, errUncorrected, evEnabled, 28'h0000000}; // R11 R15
            addrLoReg <= errAddr[31:0];
            addrHiReg <= errAddr[63:32];
        end else begin
            if (overflowEvent) begin
                statHiReg[ST_OVERFLOW] <= 1'b1;
            end else if (wrStatHi) begin
                statHiReg <= wrData;
            end
            if (wrStatLo) begin
                statLoReg <= wrData;
            end
            if (wrAddrLo) begin
                addrLoReg <= wrData;
            end
            if (wrAddrHi) begin
                addrHiReg <= wrData;
            end
        end
    end

    // plain storage for the remaining read/write words
    genvar gi;
    generate
        for (gi = 0; gi < MISC_COUNT; gi++) begin : g_misc
            localparam logic [31:0] RESET_VALUE = (gi == 0) ? MEMCTL_XBAR_RESET :
                                                  (gi == 1) ? FREE_LIST_RESET :
                                                  MISC_DEFAULT_RESET;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    miscReg[gi] <= RESET_VALUE;
                end else if (wrMisc && (miscIdx == 4'(gi))) begin
                    miscReg[gi] <= wrData;
                end
            end
        end
    endgenerate

    // error actions; flooding and abort answers ignore the reporting enables
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mcReport <= 1'b0;
            syncFlood <= 1'b0;
            errRespValid <= 1'b0;
            errRespData <= 32'h0000_0000;
        end else begin
            mcReport <= reportEvent; // R8 R9
            if (warmReset) begin
                syncFlood <= 1'b0;
            end else if (floodEvent) begin
                syncFlood <= 1'b1; // R16
            end
            errRespValid <= abortEvent; // R17
            errRespData <= abortEvent ? ALL_ONES : 32'h0000_0000;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_reserved_zero;
        (enablesReg & ~ENABLES_MASK) == 32'h0000_0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved enable set"); // R14

    property p_unimpl_zero;
        (cfgReq && !cfgWrite && cfgAddr == 12'h010) |=> (cfgAck && cfgRdata == 32'h0000_0000);
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented not zero"); // R1

    property p_ident;
        (cfgReq && !cfgWrite && wordAddr == OFF_IDENT) |=>
            cfgRdata == {DEVICE_CODE, MAKER_CODE};
    endproperty
    a_ident: assert property (p_ident) else $error("identity word wrong"); // R3

    property p_class;
        (cfgReq && !cfgWrite && wordAddr == OFF_CLASS) |=> cfgRdata[31:8] == 24'h060000;
    endproperty
    a_class: assert property (p_class) else $error("class word wrong"); // R4

    property p_header;
        (cfgReq && !cfgWrite && wordAddr == OFF_HEADER) |=> cfgRdata == 32'h0080_0000;
    endproperty
    a_header: assert property (p_header) else $error("header word wrong"); // R5

    property p_report_gate;
        mcReport |-> $past(errValid && globalMcEn && evEnabled && !isCorrectable);
    endproperty
    a_report_gate: assert property (p_report_gate) else $error("report not gated"); // R9

    property p_corr_silent;
        (errValid && isCorrectable) |=> !mcReport;
    endproperty
    a_corr_silent: assert property (p_corr_silent) else $error("correctable reported"); // R15

    property p_flood;
        (floodEvent && !warmReset) |=> syncFlood ##1 (syncFlood || $past(warmReset));
    endproperty
    a_flood: assert property (p_flood) else $error("no flood after link error"); // R16

    property p_abort_resp;
        abortEvent |=> (errRespValid && errRespData == 32'hFFFF_FFFF);
    endproperty
    a_abort_resp: assert property (p_abort_resp) else $error("abort answer wrong"); // R17

    property p_side_no_action;
        (sideWr && !warmReset) |=> $stable(actionReg);
    endproperty
    a_side_no_action: assert property (p_side_no_action) else $error("side path hit action"); // R7

    property p_log_keep;
        (warmReset && !errValid && !wrStatHi) |=> $stable(statHiReg);
    endproperty
    a_log_keep: assert property (p_log_keep) else $error("log lost on warm reset"); // R10

    property p_capture;
        captureEvent |=> (statLoReg[4:0] == $past(errType) && addrLoReg == $past(errAddr[31:0]));
    endproperty
    a_capture: assert property (p_capture) else $error("log capture wrong"); // R11

    c_report: cover property (reportEvent ##1 mcReport);
    c_flood: cover property (floodEvent ##1 syncFlood);
    c_overflow: cover property (overflowEvent);
endmodule // misc_config_header

// >>> tb/misc_config_header_mca_control_test.sv
// self-checking bench for the configuration header and error-reporting bank
`timescale 1ns/1ps
module misc_config_header_mca_control_test import misc_cfg_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic warmReset = 1'b0;
    logic globalMcEn = 1'b0;
    logic cfgReq = 1'b0;
    logic cfgWrite = 1'b0;
    logic [11:0] cfgAddr = 12'h000;
    logic [31:0] cfgWdata = 32'h0;
    logic [31:0] cfgRdata;
    logic cfgAck;
    logic msrReq = 1'b0;
    logic msrWrite = 1'b0;
    logic [2:0] msrSel = 3'h0;
    logic [31:0] msrWdata = 32'h0;
    logic [31:0] msrRdata;
    logic msrAck;
    logic errValid = 1'b0;
    logic [4:0] errType = 5'h00;
    logic errUncorrected = 1'b0;
    logic [63:0] errAddr = 64'h0;
    logic mcReport;
    logic syncFlood;
    logic errRespValid;
    logic [31:0] errRespData;
    int nErrors = 0;
    int nTests = 0;
    // expected word per offset; absent offsets read zero
    logic [31:0] model [int];
    misc_config_header i_dut (.clk(clk), .rst_n(rst_n), .warmReset(warmReset),
        .globalMcEn(globalMcEn), .cfgReq(cfgReq), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr),
        .cfgWdata(cfgWdata), .cfgRdata(cfgRdata), .cfgAck(cfgAck), .msrReq(msrReq),
        .msrWrite(msrWrite), .msrSel(msrSel), .msrWdata(msrWdata), .msrRdata(msrRdata),
        .msrAck(msrAck), .errValid(errValid), .errType(errType),
        .errUncorrected(errUncorrected), .errAddr(errAddr), .mcReport(mcReport),
        .syncFlood(syncFlood), .errRespValid(errRespValid), .errRespData(errRespData));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic endOfTest();
        $display("checks %0d mismatches %0d", nTests, nErrors);
        if (nErrors == 0 && nTests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        nTests++;
        if (g !== e) begin
            nErrors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one-cycle request; answer is looked at in the cycle after the taking edge
    task automatic cfg(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r);
        @(negedge clk);
        cfgReq = 1'b1;
        cfgWrite = w;
        cfgAddr = a;
        cfgWdata = d;
        @(posedge clk);
        @(negedge clk);
        cfgReq = 1'b0;
        chk("cfgAck", 32'h1, {31'h0, cfgAck});
        r = cfgRdata;
    endtask
    task automatic msr(input logic w, input logic [2:0] s, input logic [31:0] d,
            output logic [31:0] r);
        @(negedge clk);
        msrReq = 1'b1;
        msrWrite = w;
        msrSel = s;
        msrWdata = d;
        @(posedge clk);
        @(negedge clk);
        msrReq = 1'b0;
        chk("msrAck", 32'h1, {31'h0, msrAck});
        r = msrRdata;
    endtask
    task automatic ev(input int t, input logic u, input logic [63:0] ad);
        @(negedge clk);
        errValid = 1'b1;
        errType = 5'(t);
        errUncorrected = u;
        errAddr = ad;
        @(posedge clk);
        @(negedge clk);
        errValid = 1'b0;
    endtask
    function automatic logic [31:0] wmask(input int a);
        if (a == 'h40) return ENABLES_MASK;
        if (a == 'h44) return ACTION_MASK;
        if (a >= 'h78 && a <= 'hDC && model.exists(a)) return ALL_ONES;
        return 32'h0;
    endfunction
    // whole standard space except the logs; optional random write to each word just before its read
    task automatic sweep(input logic wr);
        logic [31:0] r;
        logic [31:0] d;
        logic [31:0] m;
        for (int a = 0; a < 'h100; a += 4) begin
            if (a < 'h48 || a > 'h54) begin
                if (wr) begin
                    d = $urandom;
                    m = wmask(a);
                    cfg(1'b1, 12'(a), d, r);
                    if (model.exists(a)) model[a] = (model[a] & ~m) | (d & m);
                end
                cfg(1'b0, 12'(a), 32'h0, r);
                chk($sformatf("word %h", a), model.exists(a) ? model[a] : 32'h0, r);
            end
        end
    endtask
    initial begin
        logic [31:0] r;
        logic [31:0] en;
        logic [63:0] ad;
        logic g;
        logic u;
        logic flood;
        int t;
        int store [13];
        void'($urandom(90813));
        store = '{'h78, 'h7C, 'h80, 'h84, 'h90, 'h94, 'h98, 'h9C, 'hA0, 'hB0,
            'hD4, 'hD8, 'hDC};
        foreach (store[i]) model[store[i]] = 32'h0;
        model['h78] = 32'h0800_3800;
        model['h7C] = 32'h0000_221B;
        model['h00] = {16'h5A01, 16'hC0DE};
        model['h08] = 32'h0600_0000;
        model['h0C] = 32'h0080_0000;
        model['h40] = 32'h0;
        model['h44] = 32'h0;
        model['hFC] = FAMILY_MODEL_VALUE;
        flood = 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        sweep(1'b0);
        sweep(1'b1);
        cfg(1'b1, 12'h100, ALL_ONES, r);
        cfg(1'b0, 12'h100, 32'h0, r);
        chk("extended word", 32'h0, r);
        msr(1'b1, SIDE_ENABLES, ALL_ONES, r);
        model['h40] = ENABLES_MASK;
        cfg(1'b0, OFF_ENABLES, 32'h0, r);
        chk("enables via config", ENABLES_MASK, r);
        msr(1'b0, SIDE_ENABLES, 32'h0, r);
        chk("enables via side", ENABLES_MASK, r);
        for (int s = 5; s < 8; s++) begin
            msr(1'b0, 3'(s), 32'h0, r);
            chk("side unmapped", 32'h0, r);
        end
        // config wins a same-cycle collision; the side write must not land
        @(negedge clk);
        cfgReq = 1'b1;
        cfgWrite = 1'b0;
        cfgAddr = OFF_ENABLES;
        msrReq = 1'b1;
        msrWrite = 1'b1;
        msrSel = SIDE_ENABLES;
        msrWdata = 32'h0;
        @(posedge clk);
        @(negedge clk);
        cfgReq = 1'b0;
        msrReq = 1'b0;
        chk("collision msrAck", 32'h0, {31'h0, msrAck});
        chk("collision read", ENABLES_MASK, cfgRdata);
        // the dropped side write of zero must not have landed
        cfg(1'b0, OFF_ENABLES, 32'h0, r);
        chk("enables after collision", ENABLES_MASK, r);
        for (int i = 0; i < 14; i++) begin
            t = (i < 13) ? i : 18;
            en = $urandom & ENABLES_MASK;
            cfg(1'b1, OFF_ENABLES, en, r);
            model['h40] = en;
            g = 1'($urandom);
            globalMcEn = g;
            cfg(1'b1, OFF_STAT_HI, 32'h0, r);
            u = 1'($urandom);
            ad = {$urandom, $urandom};
            ev(t, u, ad);
            chk("mcReport", {31'h0, en[t] & g & (t != 0)}, {31'h0, mcReport});
            chk("errRespValid", {31'h0, t == 8 || t == 9}, {31'h0, errRespValid});
            chk("errRespData", (t == 8 || t == 9) ? ALL_ONES : 32'h0, errRespData);
            flood = flood | (t >= 2 && t <= 7);
            chk("syncFlood", {31'h0, flood}, {31'h0, syncFlood});
            msr(1'b0, SIDE_STAT_LO, 32'h0, r);
            chk("status low", 32'(t), r);
            msr(1'b0, SIDE_STAT_HI, 32'h0, r);
            chk("status high", {1'b1, 1'b0, u, en[t], 28'h0}, r);
            msr(1'b0, SIDE_ADDR_LO, 32'h0, r);
            chk("address low", ad[31:0], r);
            cfg(1'b0, OFF_ADDR_HI, 32'h0, r);
            chk("address high", ad[63:32], r);
        end
        // second event while a log is held only marks overflow
        ev(1, 1'b0, 64'h0);
        cfg(1'b0, OFF_STAT_HI, 32'h0, r);
        chk("overflow", 32'h3, {30'h0, r[31:30]});
        @(negedge clk);
        warmReset = 1'b1;
        @(negedge clk);
        warmReset = 1'b0;
        model['h40] = 32'h0;
        model['h44] = 32'h0;
        chk("flood after warm", 32'h0, {31'h0, syncFlood});
        cfg(1'b0, OFF_STAT_LO, 32'h0, r);
        chk("status low kept", 32'd18, r);
        msr(1'b0, SIDE_ADDR_LO, 32'h0, r);
        chk("address kept", ad[31:0], r);
        sweep(1'b0);
        endOfTest();
    end
    initial begin
        repeat (60000) @(posedge clk);
        nErrors++;
        $display("MISMATCH run length expected finish seen hang");
        endOfTest();
    end
endmodule // misc_config_header_mca_control_test
